// ===== ddrc_pkg.sv
// Shared constants, field layouts and carrier types of the SDRAM controller register front end.
package ddrc_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_REVISION = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_REFRESH = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TIMING_ONE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TIMING_TWO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CONFIG_TWO = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_BURST_PRIO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PC_ONE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PC_TWO = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_PC_SETUP = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_PC_REGION = 8'h4c;
  localparam logic [ADDR_W-1:0] OFS_PC_TIME = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_IRQ_RAW = 8'hc0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASKED = 8'hc4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_SET = 8'hc8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK_CLR = 8'hcc;
  localparam logic [ADDR_W-1:0] OFS_PHY_CONTROL = 8'he4;

  // ==========================================================================
  // Status word layout
  // ==========================================================================
  localparam int STAT_DUAL_CLOCK_BIT = 30;
  localparam int STAT_PHY_READY_BIT = 2;

  // ==========================================================================
  // Configuration word layout, masks and reset values
  // ==========================================================================
  localparam int CFG_TERM_HI_BIT = 27;
  localparam int CFG_BANK_POS_BIT = 26;
  localparam int CFG_MOBILE_BIT = 25;
  localparam int CFG_DRIVE_HI_BIT = 24;
  localparam int CFG_BOOT_UNLOCK_BIT = 23;
  localparam int CFG_DIFF_STROBE_BIT = 22;
  localparam int CFG_TERM_LO_BIT = 21;
  localparam int CFG_SECOND_GEN_BIT = 20;
  localparam int CFG_MEM_DLL_DIS_BIT = 19;
  localparam int CFG_DRIVE_LO_BIT = 18;
  localparam int CFG_DOUBLE_RATE_BIT = 17;
  localparam int CFG_SYNC_DRAM_BIT = 16;
  localparam int CFG_TIMING_UNLOCK_BIT = 15;
  localparam int CFG_BUS_WIDTH_BIT = 14;
  localparam int CFG_CAS_LSB = 9;
  localparam int CFG_BANKS_LSB = 4;
  localparam int CFG_COLUMN_LSB = 0;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0813_4a20;
  localparam logic [DATA_W-1:0] CFG_BOOT_MASK = 32'h0b7f_0000;
  localparam logic [DATA_W-1:0] CFG_TIMING_MASK = 32'h0000_0e00;
  localparam logic [DATA_W-1:0] CFG_FREE_MASK = 32'h0480_c077;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 32'h0fff_ce77;

  // ==========================================================================
  // Other register masks and reset values
  // ==========================================================================
  localparam logic [DATA_W-1:0] REFRESH_RESET = 32'h0000_0884;
  localparam logic [DATA_W-1:0] REFRESH_MASK = 32'hc080_ffff;
  localparam logic [DATA_W-1:0] TIMING_ONE_RESET = 32'h1e92_3249;
  localparam logic [DATA_W-1:0] TIMING_ONE_MASK = 32'hffff_fffb;
  localparam int PLAIN_COUNT = 5;
  localparam logic [2:0] PLAIN_NONE = 3'h7;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [1:0] termination;
    logic bank_position_select;
    logic mobile_sdram_enable;
    logic [1:0] drive_strength;
    logic diff_strobe_enable;
    logic second_gen_enable;
    logic mem_dll_disable;
    logic double_rate_enable;
    logic sync_dram_enable;
    logic bus_width_select;
    logic [2:0] cas_latency;
    logic [2:0] internal_bank_count;
    logic [2:0] column_width_select;
  } ddrc_mem_cfg_s;

  typedef struct packed {
    logic dll_powered;
    logic dll_locked;
    logic dll_in_reset;
    logic init_done;
  } ddrc_mem_status_s;

endpackage

// ===== ddrc_sync.sv
// Two-stage level synchroniser for signals arriving from the memory clock domain.
`timescale 1ns/1ps
`default_nettype none
module ddrc_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ddrc_sync_state_s;

  ddrc_sync_state_s state_ff;
  ddrc_sync_state_s nxt_state;

  // Only the second stage is visible; the first may be metastable.
  always_comb begin
    nxt_state.meta = i_async;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_sync = state_ff.sync;

endmodule
`default_nettype wire

// ===== ddrc_init_track.sv
// Tracks an SDRAM initialization request from start until the memory side reports done.
`timescale 1ns/1ps
`default_nettype none
module ddrc_init_track (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_done,
  output logic o_busy
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic busy;
  } ddrc_init_state_s;

  ddrc_init_state_s state_ff;
  ddrc_init_state_s nxt_state;

  // A new start wins over a done seen in the same cycle, so no request is lost.
  always_comb begin
    nxt_state = state_ff;
    if (i_start) begin
      nxt_state.busy = 1'b1;
    end else if (i_done) begin
      nxt_state.busy = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_busy = state_ff.busy;

endmodule
`default_nettype wire

// ===== ddrc_regs.sv
// Register front end of the SDRAM controller: decode, configuration, status and unlock handling.
//
// ============================================================================
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module ddrc_regs #(
  // Arbitrary identification value, not tied to any real part.
  parameter logic [31:0] REVISION_VALUE = 32'h0a5c_0001,
  parameter logic [31:0] TIMING_TWO_RESET = 32'h0000_0000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [ddrc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ddrc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire ddrc_pkg::ddrc_mem_status_s i_mem_status,
  output logic [ddrc_pkg::DATA_W-1:0] o_rdata,
  output ddrc_pkg::ddrc_mem_cfg_s o_mem_cfg,
  output logic [ddrc_pkg::DATA_W-1:0] o_refresh,
  output logic [ddrc_pkg::DATA_W-1:0] o_timing_one,
  output logic [ddrc_pkg::DATA_W-1:0] o_timing_two,
  output logic [ddrc_pkg::DATA_W-1:0] o_config_two,
  output logic [ddrc_pkg::DATA_W-1:0] o_phy_control,
  output logic o_init_start,
  output logic o_init_busy
);

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // Plain read/write registers whose contents this block only stores.
  function automatic logic [2:0] plain_index(input logic [ddrc_pkg::ADDR_W-1:0] addr);
    logic [2:0] idx;
    idx = ddrc_pkg::PLAIN_NONE;
    unique case (addr)
      ddrc_pkg::OFS_CONFIG_TWO: idx = 3'h0;
      ddrc_pkg::OFS_BURST_PRIO: idx = 3'h1;
      ddrc_pkg::OFS_PC_SETUP: idx = 3'h2;
      ddrc_pkg::OFS_PC_REGION: idx = 3'h3;
      ddrc_pkg::OFS_PHY_CONTROL: idx = 3'h4;
      default: idx = ddrc_pkg::PLAIN_NONE;
    endcase
    return idx;
  endfunction

  // Counter and interrupt words are decoded but read zero in this front end.
  function automatic logic zero_word(input logic [ddrc_pkg::ADDR_W-1:0] addr);
    return (addr == ddrc_pkg::OFS_PC_ONE) || (addr == ddrc_pkg::OFS_PC_TWO) ||
           (addr == ddrc_pkg::OFS_PC_TIME) || (addr == ddrc_pkg::OFS_IRQ_RAW) ||
           (addr == ddrc_pkg::OFS_IRQ_MASKED) || (addr == ddrc_pkg::OFS_IRQ_MASK_SET) ||
           (addr == ddrc_pkg::OFS_IRQ_MASK_CLR);
  endfunction

  function automatic ddrc_pkg::ddrc_mem_cfg_s to_mem_cfg(input logic [31:0] w);
    ddrc_pkg::ddrc_mem_cfg_s c;
    c.termination = {w[ddrc_pkg::CFG_TERM_HI_BIT], w[ddrc_pkg::CFG_TERM_LO_BIT]};
    c.bank_position_select = w[ddrc_pkg::CFG_BANK_POS_BIT];
    c.mobile_sdram_enable = w[ddrc_pkg::CFG_MOBILE_BIT];
    c.drive_strength = {w[ddrc_pkg::CFG_DRIVE_HI_BIT], w[ddrc_pkg::CFG_DRIVE_LO_BIT]};
    c.diff_strobe_enable = w[ddrc_pkg::CFG_DIFF_STROBE_BIT];
    c.second_gen_enable = w[ddrc_pkg::CFG_SECOND_GEN_BIT];
    c.mem_dll_disable = w[ddrc_pkg::CFG_MEM_DLL_DIS_BIT];
    c.double_rate_enable = w[ddrc_pkg::CFG_DOUBLE_RATE_BIT];
    c.sync_dram_enable = w[ddrc_pkg::CFG_SYNC_DRAM_BIT];
    c.bus_width_select = w[ddrc_pkg::CFG_BUS_WIDTH_BIT];
    c.cas_latency = w[ddrc_pkg::CFG_CAS_LSB +: 3];
    c.internal_bank_count = w[ddrc_pkg::CFG_BANKS_LSB +: 3];
    c.column_width_select = w[ddrc_pkg::CFG_COLUMN_LSB +: 3];
    return c;
  endfunction

  // ==========================================================================
  // Memory-side status crossing
  // ==========================================================================
  ddrc_pkg::ddrc_mem_status_s mem_status_sync;
  logic phy_ready;

  ddrc_sync #(
    .WIDTH($bits(ddrc_pkg::ddrc_mem_status_s))
  ) u_status_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_mem_status),
    .o_sync(mem_status_sync)
  );

  // All three DLL conditions must hold together before software sees ready.
  assign phy_ready = mem_status_sync.dll_powered & mem_status_sync.dll_locked &
                     ~mem_status_sync.dll_in_reset;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0] config_word;
    logic [31:0] refresh;
    logic [31:0] timing_one;
    logic [31:0] timing_two;
    logic [ddrc_pkg::PLAIN_COUNT-1:0][31:0] plain;
    logic [31:0] rdata;
    logic init_start;
  } ddrc_regs_state_s;

  ddrc_regs_state_s state_ff;
  ddrc_regs_state_s nxt_state;
  logic boot_open;
  logic timing_open;
  logic [31:0] cfg_accept;
  logic [31:0] status_word;
  logic [2:0] wr_plain;
  logic [2:0] rd_plain;

  assign boot_open = state_ff.config_word[ddrc_pkg::CFG_BOOT_UNLOCK_BIT];
  assign timing_open = state_ff.config_word[ddrc_pkg::CFG_TIMING_UNLOCK_BIT];
  assign wr_plain = plain_index(i_addr);
  assign rd_plain = plain_index(i_addr);

  // Protected fields follow the lock as it stood before this write, so the closing write lands.
  assign cfg_accept = ddrc_pkg::CFG_FREE_MASK |
                      (boot_open ? ddrc_pkg::CFG_BOOT_MASK : '0) |
                      (timing_open ? ddrc_pkg::CFG_TIMING_MASK : '0);

  always_comb begin
    status_word = '0;
    status_word[ddrc_pkg::STAT_DUAL_CLOCK_BIT] = 1'b1;
    status_word[ddrc_pkg::STAT_PHY_READY_BIT] = phy_ready;
  end

  // ==========================================================================
  // Write and read path
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_state.init_start = 1'b0;
    nxt_state.rdata = '0;
    if (i_wr) begin
      unique case (i_addr)
        ddrc_pkg::OFS_CONFIG: begin
          // Every config write carries bank count and column width, so it restarts init.
          nxt_state.config_word = (state_ff.config_word & ~cfg_accept) |
                                  (i_wdata & cfg_accept);
          nxt_state.init_start = 1'b1;
        end
        ddrc_pkg::OFS_REFRESH: begin
          nxt_state.refresh = i_wdata & ddrc_pkg::REFRESH_MASK;
        end
        ddrc_pkg::OFS_TIMING_ONE: begin
          if (timing_open) begin
            nxt_state.timing_one = i_wdata & ddrc_pkg::TIMING_ONE_MASK;
          end
        end
        ddrc_pkg::OFS_TIMING_TWO: begin
          if (timing_open) begin
            nxt_state.timing_two = i_wdata;
          end
        end
        default: begin
          for (int i = 0; i < ddrc_pkg::PLAIN_COUNT; i++) begin
            if (wr_plain == 3'(i)) begin
              nxt_state.plain[i] = i_wdata;
            end
          end
        end
      endcase
    end
    if (i_rd) begin
      // Revision writes fall through the case above untouched.
      unique case (i_addr)
        ddrc_pkg::OFS_REVISION: nxt_state.rdata = REVISION_VALUE;
        ddrc_pkg::OFS_STATUS: nxt_state.rdata = status_word;
        ddrc_pkg::OFS_CONFIG: nxt_state.rdata = state_ff.config_word;
        ddrc_pkg::OFS_REFRESH: nxt_state.rdata = state_ff.refresh;
        ddrc_pkg::OFS_TIMING_ONE: nxt_state.rdata = state_ff.timing_one;
        ddrc_pkg::OFS_TIMING_TWO: nxt_state.rdata = state_ff.timing_two;
        default: begin
          // Unmapped offsets, including anything outside this block such as the trim control, read zero.
          for (int i = 0; i < ddrc_pkg::PLAIN_COUNT; i++) begin
            if (rd_plain == 3'(i) && !zero_word(i_addr)) begin
              nxt_state.rdata = state_ff.plain[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_ff.config_word <= ddrc_pkg::CFG_RESET;
      state_ff.refresh <= ddrc_pkg::REFRESH_RESET;
      state_ff.timing_one <= ddrc_pkg::TIMING_ONE_RESET;
      state_ff.timing_two <= TIMING_TWO_RESET;
      state_ff.plain <= '0;
      state_ff.rdata <= '0;
      state_ff.init_start <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Initialization tracking
  // ==========================================================================
  ddrc_init_track u_init_track (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(state_ff.init_start),
    .i_done(mem_status_sync.init_done),
    .o_busy(o_init_busy)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_rdata = state_ff.rdata;
  assign o_mem_cfg = to_mem_cfg(state_ff.config_word);
  assign o_refresh = state_ff.refresh;
  assign o_timing_one = state_ff.timing_one;
  assign o_timing_two = state_ff.timing_two;
  assign o_config_two = state_ff.plain[0];
  assign o_phy_control = state_ff.plain[4];
  assign o_init_start = state_ff.init_start;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_cfg_write_locked;
    i_wr && i_addr == ddrc_pkg::OFS_CONFIG && !boot_open;
  endsequence

  sequence s_cfg_write_open;
    i_wr && i_addr == ddrc_pkg::OFS_CONFIG && boot_open;
  endsequence

  sequence s_unlock_then_close;
    (i_wr && i_addr == ddrc_pkg::OFS_CONFIG && i_wdata[ddrc_pkg::CFG_BOOT_UNLOCK_BIT]) ##1
    (i_wr && i_addr == ddrc_pkg::OFS_CONFIG && !i_wdata[ddrc_pkg::CFG_BOOT_UNLOCK_BIT]);
  endsequence

  AST_REVISION_FIXED: assert property (i_rd && i_addr == ddrc_pkg::OFS_REVISION |=> o_rdata == REVISION_VALUE)
    else $error("Revision read returned a wrong value.");

  AST_DUAL_CLOCK_ONE: assert property (i_rd && i_addr == ddrc_pkg::OFS_STATUS |=> o_rdata[ddrc_pkg::STAT_DUAL_CLOCK_BIT])
    else $error("Dual clock flag did not read one.");

  AST_PHY_READY_READ: assert property (i_rd && i_addr == ddrc_pkg::OFS_STATUS |=>
    o_rdata[ddrc_pkg::STAT_PHY_READY_BIT] == $past(phy_ready) &&
    o_rdata[ddrc_pkg::STAT_PHY_READY_BIT] == ($past(mem_status_sync.dll_powered) &&
    $past(mem_status_sync.dll_locked) && !$past(mem_status_sync.dll_in_reset)))
    else $error("DLL ready bit does not match the DLL state.");

  AST_INIT_ON_CFG_WRITE: assert property (i_wr && i_addr == ddrc_pkg::OFS_CONFIG |=> o_init_start ##1 o_init_busy)
    else $error("Config write did not start initialization.");

  AST_BOOT_LOCKED: assert property (s_cfg_write_locked |=>
    (o_mem_cfg.termination == $past(o_mem_cfg.termination)) &&
    (o_mem_cfg.drive_strength == $past(o_mem_cfg.drive_strength)) &&
    (o_mem_cfg.sync_dram_enable == $past(o_mem_cfg.sync_dram_enable)))
    else $error("Locked boot field changed on a write.");

  AST_BOOT_CLOSE_APPLIES: assert property (s_cfg_write_open |=>
    o_mem_cfg.drive_strength == {$past(i_wdata[ddrc_pkg::CFG_DRIVE_HI_BIT]), $past(i_wdata[ddrc_pkg::CFG_DRIVE_LO_BIT])} &&
    o_mem_cfg.mobile_sdram_enable == $past(i_wdata[ddrc_pkg::CFG_MOBILE_BIT]))
    else $error("Boot field write was not applied while unlocked.");

  AST_UNLOCK_SEQUENCE: assert property (s_unlock_then_close |=>
    !boot_open && o_mem_cfg.second_gen_enable == $past(i_wdata[ddrc_pkg::CFG_SECOND_GEN_BIT]))
    else $error("Unlock and close sequence did not land the new value.");

  AST_TIMING_LOCKED: assert property (i_wr && i_addr == ddrc_pkg::OFS_TIMING_ONE && !timing_open |=>
    $stable(o_timing_one))
    else $error("Timing register changed while locked.");

  AST_CAS_LOCKED: assert property (i_wr && i_addr == ddrc_pkg::OFS_CONFIG && !timing_open |=>
    $stable(o_mem_cfg.cas_latency))
    else $error("CAS latency changed while timing lock closed.");

  AST_RESERVED_ZERO: assert property (i_rd && (i_addr == ddrc_pkg::OFS_CONFIG || i_addr == ddrc_pkg::OFS_STATUS) |=>
    (o_rdata & ~(ddrc_pkg::CFG_WRITE_MASK | status_word)) == '0)
    else $error("Reserved bits read nonzero.");

  AST_READ_ONE_CYCLE: assert property (!i_rd |=> o_rdata == '0)
    else $error("Read data stood outside the answer cycle.");

  // Counter and interrupt words must never leak stored data, whatever was written there.
  AST_UNMAPPED_ZERO: assert property (i_rd && zero_word(i_addr) |=> o_rdata == '0)
    else $error("A word without storage read nonzero.");

  AST_INIT_ONLY_ON_CFG: assert property (!(i_wr && i_addr == ddrc_pkg::OFS_CONFIG) |=> !o_init_start)
    else $error("Initialization started without a config write.");

  AST_FREE_FIELDS_WRITE: assert property (i_wr && i_addr == ddrc_pkg::OFS_CONFIG |=>
    o_mem_cfg.bank_position_select == $past(i_wdata[ddrc_pkg::CFG_BANK_POS_BIT]) &&
    o_mem_cfg.internal_bank_count == $past(i_wdata[ddrc_pkg::CFG_BANKS_LSB +: 3]) &&
    o_mem_cfg.column_width_select == $past(i_wdata[ddrc_pkg::CFG_COLUMN_LSB +: 3]))
    else $error("Unprotected config field was not written.");

  AST_TIMING_TWO_LOCKED: assert property (i_wr && i_addr == ddrc_pkg::OFS_TIMING_TWO && !timing_open |=>
    $stable(o_timing_two))
    else $error("Second timing register changed while locked.");

  // Checks the open path too, so a lock that never opens cannot pass unnoticed.
  AST_TIMING_OPEN_APPLIES: assert property (i_wr && i_addr == ddrc_pkg::OFS_TIMING_ONE && timing_open |=>
    o_timing_one == ($past(i_wdata) & ddrc_pkg::TIMING_ONE_MASK))
    else $error("Timing write was not applied while unlocked.");

  AST_CAS_OPEN_APPLIES: assert property (i_wr && i_addr == ddrc_pkg::OFS_CONFIG && timing_open |=>
    o_mem_cfg.cas_latency == $past(i_wdata[ddrc_pkg::CFG_CAS_LSB +: 3]))
    else $error("CAS latency write was not applied while unlocked.");

endmodule
`default_nettype wire

// ===== ddrc_mem_model.sv
// Behavioural model of the memory side: DLL state levels and an init sequence that ends after a delay.
`timescale 1ns/1ps
`default_nettype none
module ddrc_mem_model #(
  parameter int INIT_CYCLES = 12
) (
  input wire logic i_clk,
  input wire logic i_init_start,
  input wire logic [2:0] i_dll,
  output ddrc_pkg::ddrc_mem_status_s o_status
);
  // ==========================================================================
  // Init sequence and DLL levels
  // ==========================================================================
  int cnt = 0;
  // Done drops at the edge that takes a new start, yet its synchronised copy still reads high, so busy clears one cycle later.
  always @(posedge i_clk) begin
    if (i_init_start) begin
      cnt <= INIT_CYCLES;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Done changes on the bus clock edge; only the DLL levels come straight from the input with no clock of their own.
  assign o_status = {i_dll, cnt == 0};
endmodule
`default_nettype wire

// ===== ddrc_regs_tb.sv
// Self-checking testbench of the SDRAM controller register front end.
`timescale 1ns/1ps
`default_nettype none
module ddrc_regs_tb;
  // Arbitrary identification value for the revision word.
  localparam logic [31:0] REV_ID = 32'h0a5c_0001;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] dll = 3'h0;
  ddrc_pkg::ddrc_mem_status_s mem_status;
  ddrc_pkg::ddrc_mem_cfg_s o_mem_cfg;
  logic [31:0] o_rdata;
  logic o_init_start;
  logic o_init_busy;
  int err_total = 0;
  int samples_checked = 0;
  logic [7:0] rw_ofs [5] = '{8'h1c, 8'h20, 8'h48, 8'h4c, 8'he4};
  logic [7:0] ro_ofs [9] = '{8'h40, 8'h44, 8'h50, 8'hc0, 8'hc4, 8'hc8, 8'hcc, 8'h18, 8'h09};
  logic [2:0] dll_cases [4] = '{3'h6, 3'h4, 3'h7, 3'h2};

  // ==========================================================================
  // Design and memory-side model
  // ==========================================================================
  ddrc_regs #(.REVISION_VALUE(REV_ID)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_mem_status(mem_status), .o_rdata(o_rdata),
    .o_mem_cfg(o_mem_cfg), .o_refresh(), .o_timing_one(), .o_timing_two(),
    .o_config_two(), .o_phy_control(), .o_init_start(o_init_start), .o_init_busy(o_init_busy)
  );
  ddrc_mem_model mem_u (.i_clk(i_clk), .i_init_start(o_init_start), .i_dll(dll), .o_status(mem_status));

  // ==========================================================================
  // Bus tasks and verdict
  // ==========================================================================
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  // ==========================================================================
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd_chk(8'h00, REV_ID);
    rd_chk(8'h08, 32'h0813_4a20);
    rd_chk(8'h0c, 32'h0000_0884);
    wr(8'h00, 32'hffff_ffff);
    rd_chk(8'h00, REV_ID);
    foreach (rw_ofs[i]) begin
      wr(rw_ofs[i], 32'h5a5a_0000 | rw_ofs[i]);
      rd_chk(rw_ofs[i], 32'h5a5a_0000 | rw_ofs[i]);
    end
    foreach (ro_ofs[i]) begin
      wr(ro_ofs[i], 32'hffff_ffff);
      rd_chk(ro_ofs[i], 32'h0000_0000);
    end
    wr(8'h0c, 32'hffff_ffff);
    rd_chk(8'h0c, 32'hc080_ffff);
    foreach (dll_cases[i]) begin
      dll <= dll_cases[i];
      repeat (4) @(posedge i_clk);
      rd_chk(8'h04, 32'h4000_0000 | (dll_cases[i] == 3'h6 ? 32'h4 : 32'h0));
    end
    wr(8'h08, 32'h874b_6b3a);
    #1 chk({31'h0, o_init_start}, 32'h1);
    @(posedge i_clk);
    #1 chk({31'h0, o_init_busy, o_init_start}, 32'h2);
    for (int n = 0; n < 60 && o_init_busy !== 1'b0; n++) @(posedge i_clk);
    chk({31'h0, o_init_busy}, 32'h0);
    rd_chk(8'h08, 32'h0c13_4a32);
    wr(8'h08, 32'h0c93_4a32);
    rd_chk(8'h08, 32'h0c93_4a32);
    wr(8'h08, 32'h874b_6b3a);
    rd_chk(8'h08, 32'h074b_4a32);
    chk({11'h000, o_mem_cfg}, 32'h0007_5f5a);
    wr(8'h10, 32'h0000_0000);
    rd_chk(8'h10, 32'h1e92_3249);
    wr(8'h08, 32'h074b_ca32);
    wr(8'h10, 32'h1234_5678);
    wr(8'h08, 32'h074b_4632);
    rd_chk(8'h08, 32'h074b_4632);
    rd_chk(8'h10, 32'h1234_5678);
    wr(8'h08, 32'h074b_4a32);
    rd_chk(8'h08, 32'h074b_4632);
    end_sim;
  end
endmodule
`default_nettype wire
